// file: verilog/dio_params.svh
// Purpose: offsets, field widths, response codes and timing counts of the line controller
// Assumes: byte addresses on a 32-bit register bus, one aligned word per register
// Notes: included by bare name
`ifndef DIO_PARAMS_SVH
`define DIO_PARAMS_SVH

`define DIO_LINES 2
`define DIO_ADDR_W 8
`define DIO_MODE_W 4
`define DIO_NOTIFY_W 2

`define DIO_OFS_MODE 8'h00
`define DIO_OFS_NOTIFY 8'h04
`define DIO_OFS_OUT 8'h08
`define DIO_OFS_INPUT 8'h0C
`define DIO_OFS_STATUS 8'h10
`define DIO_OFS_MASK 8'h14
`define DIO_OFS_EFF 8'h18

`define DIO_RESP_OKAY 2'h0
`define DIO_RESP_SLVERR 2'h2

`define DIO_CLOCK_KHZ 20000
`define DIO_SETTLE_US 100
`define DIO_SETTLE_CYCLES ((`DIO_SETTLE_US * `DIO_CLOCK_KHZ + 999) / 1000)

`endif

// file: verilog/dio_pkg.sv
// Purpose: shared types of the line controller
// Assumes: codes of the enums are the implicit ones, counting from zero in declaration order
// Notes: never imported, always used with the package scope
package dio_pkg;

   typedef enum logic [3:0] {
      mode_host,
      mode_di_sink24,
      mode_di_sink24_pm,
      mode_di_logic,
      mode_di_contact,
      mode_do_sink,
      mode_do_source,
      mode_do_open,
      mode_do_push_pull
   } mode_t;

   typedef enum logic [1:0] {
      notify_off,
      notify_fall,
      notify_rise
   } notify_t;

   typedef enum logic [1:0] {
      rd_idle,
      rd_sample,
      rd_resp
   } rd_state_t;

endpackage

// file: verilog/dio_line_drive.sv
// Purpose: pad control of one line from its effective mode
// Assumes: mode is already resolved, never the host-driven code
// Notes: purely combinational
`timescale 1ns/1ps
module dio_line_drive (
   input wire dio_pkg::mode_t mode,
   input wire logic out_value,
   input wire logic supply_ok,
   input wire logic active,
   output logic pad_out,
   output logic pad_oe,
   output logic pullup_en,
   output logic gnd_path_en
);

   always_comb begin
      pad_out = 1'b0;
      pad_oe = 1'b0;
      pullup_en = 1'b0;
      gnd_path_en = 1'b0;
      case (mode)
         dio_pkg::mode_di_sink24: begin
            gnd_path_en = 1'b1;
         end
         dio_pkg::mode_di_sink24_pm: begin
            gnd_path_en = active;
         end
         dio_pkg::mode_di_contact: begin
            pullup_en = active;
         end
         dio_pkg::mode_do_sink: begin
            pad_oe = ~out_value;
         end
         dio_pkg::mode_do_source: begin
            pad_out = 1'b1;
            pad_oe = out_value;
         end
         dio_pkg::mode_do_open: begin
            pad_oe = ~out_value;
            pullup_en = 1'b1;
         end
         dio_pkg::mode_do_push_pull: begin
            // without supply only the low side works
            pad_out = out_value & supply_ok;
            pad_oe = supply_ok | ~out_value;
         end
         default: begin
            pad_oe = 1'b0;
         end
      endcase
   end

endmodule // dio_line_drive

// file: verilog/dio_mode_control.sv
// Purpose: per-line mode, drive, power-managed sampling and edge notification
// Assumes: AXI4-Lite register access, pins sampled through two flip-flops
// Notes: reads of the input word wait for the settle time while gating applies
`timescale 1ns/1ps
`include "dio_params.svh"
module dio_mode_control #(
   parameter int LINES = `DIO_LINES,
   parameter int ADDR_W = `DIO_ADDR_W,
   parameter int SETTLE_CYCLES = `DIO_SETTLE_CYCLES
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [`DIO_MODE_W*LINES-1:0] host_mode,
   input wire logic output_supply_pin,
   input wire logic [LINES-1:0] line_in,
   output logic [LINES-1:0] line_out,
   output logic [LINES-1:0] line_oe,
   output logic [LINES-1:0] pullup_en,
   output logic [LINES-1:0] gnd_path_en,
   output logic irq
);

   localparam int MW = `DIO_MODE_W;
   localparam int NW = `DIO_NOTIFY_W;

   // ****************************************************************
   // register state
   // ****************************************************************
   logic [MW*LINES-1:0] mode_reg;
   logic [NW*LINES-1:0] notify_reg;
   logic [LINES-1:0] out_reg;
   logic [LINES-1:0] status_reg;
   logic [LINES-1:0] mask_reg;
   logic [LINES-1:0] in_meta_reg;
   logic [LINES-1:0] in_sync_reg;
   logic [LINES-1:0] in_prev_reg;
   logic [LINES-1:0] armed_reg;
   logic supply_meta_reg;
   logic supply_sync_reg;

   logic aw_hold_reg;
   logic w_hold_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;

   dio_pkg::rd_state_t rd_state_reg;
   logic [15:0] settle_cnt_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   logic do_write;
   logic [ADDR_W-1:0] w_word;
   logic [ADDR_W-1:0] r_word;
   logic [LINES-1:0] sampling;
   logic [LINES-1:0] edge_hit;
   logic [LINES-1:0] status_clr;
   logic need_gate;
   logic sample_active;
   dio_pkg::mode_t eff_mode [LINES];
   logic [MW*LINES-1:0] eff_flat;
   logic [31:0] rd_word;
   logic rd_hit;

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         in_meta_reg <= '0;
         in_sync_reg <= '0;
         supply_meta_reg <= 1'b0;
         supply_sync_reg <= 1'b0;
      end else begin
         in_meta_reg <= line_in;
         in_sync_reg <= in_meta_reg;
         supply_meta_reg <= output_supply_pin;
         supply_sync_reg <= supply_meta_reg;
      end
   end

   // ****************************************************************
   // write channel
   // ****************************************************************
   assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
   assign s_axi_wready = ~w_hold_reg & ~bvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
   assign w_word = {aw_addr_reg[ADDR_W-1:2], 2'h0};

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         aw_hold_reg <= 1'b0;
         aw_addr_reg <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
         aw_hold_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         w_hold_reg <= 1'b0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_hold_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
         w_hold_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `DIO_RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         case (w_word)
            `DIO_OFS_MODE, `DIO_OFS_NOTIFY, `DIO_OFS_OUT,
            `DIO_OFS_STATUS, `DIO_OFS_MASK: bresp_reg <= `DIO_RESP_OKAY;
            default: bresp_reg <= `DIO_RESP_SLVERR;
         endcase
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // ****************************************************************
   // settings, one field per line
   // ****************************************************************
   // codes beyond the last enum value are ignored
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         mode_reg <= {LINES{dio_pkg::mode_host}};
      end else if (do_write && w_word == `DIO_OFS_MODE) begin
         for (int i = 0; i < LINES; i++) begin
            if (w_strb_reg[(MW*i)/8] && w_data_reg[MW*i+:MW] <= dio_pkg::mode_do_push_pull) begin
               mode_reg[MW*i+:MW] <= w_data_reg[MW*i+:MW];
            end
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         notify_reg <= {LINES{dio_pkg::notify_off}};
      end else if (do_write && w_word == `DIO_OFS_NOTIFY) begin
         for (int i = 0; i < LINES; i++) begin
            if (w_strb_reg[(NW*i)/8] && w_data_reg[NW*i+:NW] <= dio_pkg::notify_rise) begin
               notify_reg[NW*i+:NW] <= w_data_reg[NW*i+:NW];
            end
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         out_reg <= '0;
      end else if (do_write && w_word == `DIO_OFS_OUT && w_strb_reg[0]) begin
         out_reg <= w_data_reg[LINES-1:0];
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         mask_reg <= '0;
      end else if (do_write && w_word == `DIO_OFS_MASK && w_strb_reg[0]) begin
         mask_reg <= w_data_reg[LINES-1:0];
      end
   end

   // ****************************************************************
   // per-line mode resolution, drive and edge detection
   // ****************************************************************
   assign sample_active = (rd_state_reg == dio_pkg::rd_sample);

   for (genvar g = 0; g < LINES; g++) begin : g_line
      dio_pkg::mode_t host_m;
      dio_pkg::notify_t note;
      assign host_m = dio_pkg::mode_t'(host_mode[MW*g+:MW]);
      assign note = dio_pkg::notify_t'(notify_reg[NW*g+:NW]);
      // host code of host-driven or beyond range falls back to high impedance
      assign eff_mode[g] = (mode_reg[MW*g+:MW] != dio_pkg::mode_host) ?
         dio_pkg::mode_t'(mode_reg[MW*g+:MW]) :
         (host_m == dio_pkg::mode_host || host_m > dio_pkg::mode_do_push_pull) ?
         dio_pkg::mode_di_logic : host_m;
      assign eff_flat[MW*g+:MW] = eff_mode[g];
      assign sampling[g] = (note != dio_pkg::notify_off) | sample_active;
      assign edge_hit[g] = armed_reg[g] & (note != dio_pkg::notify_off) &
         ((note == dio_pkg::notify_rise) ? (in_sync_reg[g] & ~in_prev_reg[g]) :
         (~in_sync_reg[g] & in_prev_reg[g]));

      dio_line_drive u_drive (
         .mode(eff_mode[g]),
         .out_value(out_reg[g]),
         .supply_ok(supply_sync_reg),
         .active(sampling[g]),
         .pad_out(line_out[g]),
         .pad_oe(line_oe[g]),
         .pullup_en(pullup_en[g]),
         .gnd_path_en(gnd_path_en[g])
      );
   end

   // arm one cycle after enabling so a stale previous sample is not used
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         in_prev_reg <= '0;
         armed_reg <= '0;
      end else begin
         in_prev_reg <= in_sync_reg;
         for (int i = 0; i < LINES; i++) begin
            armed_reg[i] <= (notify_reg[NW*i+:NW] != dio_pkg::notify_off);
         end
      end
   end

   // ****************************************************************
   // notification status and interrupt
   // ****************************************************************
   assign status_clr = (do_write && w_word == `DIO_OFS_STATUS && w_strb_reg[0]) ?
      w_data_reg[LINES-1:0] : '0;

   // a new edge wins over a clear in the same cycle
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         status_reg <= '0;
      end else begin
         status_reg <= (status_reg & ~status_clr) | edge_hit;
      end
   end

   assign irq = |(status_reg & mask_reg);

   // ****************************************************************
   // read channel with on-demand sampling
   // ****************************************************************
   always_comb begin
      need_gate = 1'b0;
      for (int i = 0; i < LINES; i++) begin
         if (notify_reg[NW*i+:NW] == dio_pkg::notify_off) begin
            need_gate = 1'b1;
         end
      end
   end

   assign r_word = {s_axi_araddr[ADDR_W-1:2], 2'h0};

   always_comb begin
      rd_word = '0;
      rd_hit = 1'b1;
      case (r_word)
         `DIO_OFS_MODE: rd_word[MW*LINES-1:0] = mode_reg;
         `DIO_OFS_NOTIFY: rd_word[NW*LINES-1:0] = notify_reg;
         `DIO_OFS_OUT: rd_word[LINES-1:0] = out_reg;
         `DIO_OFS_INPUT: rd_word[LINES-1:0] = in_sync_reg;
         `DIO_OFS_STATUS: rd_word[LINES-1:0] = status_reg;
         `DIO_OFS_MASK: rd_word[LINES-1:0] = mask_reg;
         `DIO_OFS_EFF: rd_word[MW*LINES-1:0] = eff_flat;
         default: rd_hit = 1'b0;
      endcase
   end

   assign s_axi_arready = (rd_state_reg == dio_pkg::rd_idle);
   assign s_axi_rvalid = (rd_state_reg == dio_pkg::rd_resp);
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rd_state_reg <= dio_pkg::rd_idle;
         settle_cnt_reg <= '0;
         rdata_reg <= '0;
         rresp_reg <= `DIO_RESP_OKAY;
      end else begin
         case (rd_state_reg)
            dio_pkg::rd_idle: begin
               if (s_axi_arvalid) begin
                  rdata_reg <= rd_word;
                  rresp_reg <= rd_hit ? `DIO_RESP_OKAY : `DIO_RESP_SLVERR;
                  settle_cnt_reg <= '0;
                  if (r_word == `DIO_OFS_INPUT && need_gate) begin
                     rd_state_reg <= dio_pkg::rd_sample;
                  end else begin
                     rd_state_reg <= dio_pkg::rd_resp;
                  end
               end
            end
            dio_pkg::rd_sample: begin
               // settle plus two synchroniser stages before capture
               if (settle_cnt_reg == 16'(SETTLE_CYCLES + 1)) begin
                  rdata_reg <= {{(32 - LINES){1'b0}}, in_sync_reg};
                  rd_state_reg <= dio_pkg::rd_resp;
               end else begin
                  settle_cnt_reg <= settle_cnt_reg + 16'h1;
               end
            end
            dio_pkg::rd_resp: begin
               if (s_axi_rready) begin
                  rd_state_reg <= dio_pkg::rd_idle;
               end
            end
            default: rd_state_reg <= dio_pkg::rd_idle;
         endcase
      end
   end

   // ****************************************************************
   // checks on line 0
   // ****************************************************************
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);

   mode_readback_a: assert property (
      s_axi_arvalid && s_axi_arready && r_word == `DIO_OFS_MODE |=>
      s_axi_rvalid && s_axi_rdata[MW-1:0] == $past(mode_reg[MW-1:0]))
      else $error("mode readback wrong");

   host_follow_a: assert property (
      mode_reg[MW-1:0] == dio_pkg::mode_host && host_mode[MW-1:0] == dio_pkg::mode_do_sink |->
      line_oe[0] == ~out_reg[0])
      else $error("host mode not followed");

   sink_ground_a: assert property (
      eff_mode[0] == dio_pkg::mode_di_sink24 |-> gnd_path_en[0] && !line_oe[0])
      else $error("sinking input lost ground");

   managed_ground_a: assert property (
      eff_mode[0] == dio_pkg::mode_di_sink24_pm |-> gnd_path_en[0] == sampling[0])
      else $error("managed ground path wrong");

   logic_hiz_a: assert property (
      eff_mode[0] == dio_pkg::mode_di_logic |-> !line_oe[0] && !pullup_en[0] && !gnd_path_en[0])
      else $error("logic input not high impedance");

   contact_pull_a: assert property (
      eff_mode[0] == dio_pkg::mode_di_contact && !sampling[0] |-> !pullup_en[0])
      else $error("contact pull-up not gated");

   sink_out_a: assert property (
      eff_mode[0] == dio_pkg::mode_do_sink |-> line_oe[0] == !out_reg[0] && !line_out[0])
      else $error("sinking output wrong");

   source_out_a: assert property (
      eff_mode[0] == dio_pkg::mode_do_source |-> line_oe[0] == out_reg[0] && line_out[0])
      else $error("sourcing output wrong");

   open_coll_a: assert property (
      eff_mode[0] == dio_pkg::mode_do_open |-> pullup_en[0] && line_oe[0] == !out_reg[0] && !line_out[0])
      else $error("open collector wrong");

   push_pull_a: assert property (
      eff_mode[0] == dio_pkg::mode_do_push_pull && out_reg[0] |->
      line_oe[0] == supply_sync_reg && line_out[0] == supply_sync_reg)
      else $error("push-pull high side wrong");

   notify_keep_a: assert property (
      do_write && w_word == `DIO_OFS_NOTIFY && w_data_reg[NW-1:0] == 2'h3 |=>
      $stable(notify_reg[NW-1:0]))
      else $error("illegal notify code stored");

   edge_flag_a: assert property (
      edge_hit[0] |=> status_reg[0] ##1 status_reg[0] || $past(status_clr[0]))
      else $error("edge not flagged");

   read_wait_a: assert property (
      s_axi_arvalid && s_axi_arready && r_word == `DIO_OFS_INPUT && need_gate |=>
      (sample_active && !s_axi_rvalid) [*8])
      else $error("input read answered before settling");

   continuous_a: assert property (
      notify_reg[NW-1:0] != dio_pkg::notify_off && eff_mode[0] == dio_pkg::mode_di_contact |->
      pullup_en[0])
      else $error("gating applied while notifying");

endmodule // dio_mode_control

// file: test/dio_field_model.sv
// Purpose: field source wired to the two lines
// Assumes: a managed sinking source is valid only after the ground path
// Notes: level settles DELAY_NS after the ground path appears
`timescale 1ns/1ps
module dio_field_model #(
   parameter int DELAY_NS = 150
) (
   input wire logic [1:0] line_out,
   input wire logic [1:0] line_oe,
   input wire logic [1:0] gnd_path_en,
   input wire logic [1:0] managed,
   input wire logic [1:0] level,
   output logic [1:0] line_in
);
   logic [1:0] valid;
   for (genvar i = 0; i < 2; i++) begin : g_line
      initial valid[i] = 1'b0;
      always begin
         @(posedge gnd_path_en[i]);
         #(DELAY_NS);
         valid[i] = gnd_path_en[i];
      end
      always @(negedge gnd_path_en[i]) begin
         valid[i] = 1'b0;
      end
      // unpowered source shows the inverse level
      assign line_in[i] = line_oe[i] ? line_out[i] : (managed[i] && !valid[i]) ? ~level[i] : level[i];
   end
endmodule // dio_field_model

// file: test/dio_mode_control_bench.sv
// Purpose: self-checking bench of the line controller
// Assumes: short settle count, field model on the pins
// Notes: one task per scenario
`timescale 1ns/1ps
`include "dio_params.svh"
module dio_mode_control_bench;
   logic clock, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, output_supply_pin, irq;
   logic [7:0] s_axi_awaddr, s_axi_araddr, host_mode;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp, line_in, line_out, line_oe, pullup_en, gnd_path_en, level, managed;
   int failures, checked;

   dio_mode_control #(.SETTLE_CYCLES(6)) u_dio_mode_control (.clock, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .host_mode, .output_supply_pin, .line_in, .line_out, .line_oe, .pullup_en, .gnd_path_en,
      .irq);
   dio_field_model u_dio_field_model (.line_out, .line_oe, .gnd_path_en, .managed, .level, .line_in);

   // ***************************
   // bus and check tasks
   // ***************************
   task automatic check(input bit ok, input string msg);
      checked++;
      if (!ok) begin
         failures++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit aw_done, w_done;
      int n;
      aw_done = 0;
      w_done = 0;
      n = 0;
      r = 2'h3;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_done && w_done) && n < 100) begin
         @(posedge clock);
         n++;
         if (!aw_done && s_axi_awready === 1'b1) begin
            aw_done = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_done && s_axi_wready === 1'b1) begin
            w_done = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      s_axi_bready <= 1'b1;
      while (n < 100 && r === 2'h3) begin
         @(posedge clock);
         n++;
         if (s_axi_bvalid === 1'b1) r = s_axi_bresp;
      end
      s_axi_bready <= 1'b0;
      if (n >= 100) check(0, "write hang");
   endtask

   task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      r = 2'h3;
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (s_axi_arready !== 1'b1 && n < 100);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      while (n < 100 && r === 2'h3) begin
         @(posedge clock);
         n++;
         if (s_axi_rvalid === 1'b1) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
         end
      end
      s_axi_rready <= 1'b0;
      if (n >= 100) check(0, "read hang");
   endtask

   // ***************************
   // scenarios
   // ***************************
   task automatic test_reset();
      rdr(`DIO_OFS_MODE, rd, resp);
      check(rd === 32'h0 && resp === `DIO_RESP_OKAY, "mode after reset");
      rdr(`DIO_OFS_NOTIFY, rd, resp);
      check(rd === 32'h0, "notify after reset");
      rdr(8'h1C, rd, resp);
      check(resp === `DIO_RESP_SLVERR, "unmapped read");
      wr(`DIO_OFS_INPUT, 32'h3, resp);
      check(resp === `DIO_RESP_SLVERR, "input write");
   endtask

   task automatic test_host();
      host_mode <= 8'h35;
      wr(`DIO_OFS_OUT, 32'h0, resp);
      repeat (2) @(posedge clock);
      check(line_oe[0] === 1'b1 && line_out[0] === 1'b0, "host sink low");
      check(line_oe[1] === 1'b0 && pullup_en[1] === 1'b0 && gnd_path_en[1] === 1'b0, "logic input");
      rdr(`DIO_OFS_EFF, rd, resp);
      check(rd[7:0] === 8'h35, "effective mode");
      host_mode <= 8'h00;
   endtask

   task automatic test_outputs();
      bit hi, eoe;
      for (int m = 5; m <= 8; m++) begin
         for (int v = 0; v < 2; v++) begin
            for (int s = 0; s < 2; s++) begin
               output_supply_pin <= s[0];
               wr(`DIO_OFS_MODE, m, resp);
               wr(`DIO_OFS_OUT, v, resp);
               repeat (4) @(posedge clock);
               hi = (m == 6) || (m == 8 && s == 1);
               eoe = (m == 6) ? v[0] : (hi ? 1'b1 : !v[0]);
               check(line_oe[0] === eoe, "drive enable");
               if (eoe) check(line_out[0] === (hi & v[0]), "drive level");
               if (m == 7) check(pullup_en[0] === 1'b1, "open collector pull-up");
            end
         end
      end
   endtask

   task automatic test_inputs();
      wr(`DIO_OFS_MODE, 32'h41, resp);
      repeat (2) @(posedge clock);
      check(gnd_path_en[0] === 1'b1, "plain sink ground");
      check(pullup_en[1] === 1'b0, "contact idle pull-up");
      wr(`DIO_OFS_MODE, 32'h42, resp);
      repeat (2) @(posedge clock);
      check(gnd_path_en[0] === 1'b0, "managed sink idle");
      managed <= 2'b01;
      level <= 2'b01;
      rdr(`DIO_OFS_INPUT, rd, resp);
      check(rd[1:0] === 2'b01, "managed input read");
      managed <= 2'b00;
   endtask

   task automatic test_notify();
      level <= 2'b01;
      wr(`DIO_OFS_MODE, 32'h34, resp);
      wr(`DIO_OFS_MASK, 32'h3, resp);
      wr(`DIO_OFS_NOTIFY, 32'h9, resp);
      repeat (4) @(posedge clock);
      check(pullup_en[0] === 1'b1, "continuous pull-up");
      level <= 2'b10;
      repeat (8) @(posedge clock);
      rdr(`DIO_OFS_STATUS, rd, resp);
      check(rd[1:0] === 2'b11 && irq === 1'b1, "both edges seen");
      wr(`DIO_OFS_MASK, 32'h1, resp);
      wr(`DIO_OFS_STATUS, 32'h1, resp);
      repeat (2) @(posedge clock);
      check(irq === 1'b0, "masked interrupt");
      level <= 2'b00;
      repeat (8) @(posedge clock);
      rdr(`DIO_OFS_STATUS, rd, resp);
      check(rd[1:0] === 2'b10, "wrong edge ignored");
      wr(`DIO_OFS_MODE, 32'h39, resp);
      rdr(`DIO_OFS_MODE, rd, resp);
      check(rd[7:0] === 8'h34, "illegal code ignored");
      wr(`DIO_OFS_NOTIFY, 32'hB, resp);
      rdr(`DIO_OFS_NOTIFY, rd, resp);
      check(rd[7:0] === 8'h09, "illegal notify code ignored");
      wr(`DIO_OFS_NOTIFY, 32'h0, resp);
      repeat (2) @(posedge clock);
      check(pullup_en[0] === 1'b0, "gating back");
   endtask

   task automatic finish_test();
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      finish_test();
   end

   initial begin
      {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {output_supply_pin, managed, s_axi_awaddr, s_axi_araddr, s_axi_wdata, host_mode, level} = '0;
      s_axi_wstrb = 4'hF;
      repeat (12) @(posedge clock);
      reset_n <= 1'b1;
      test_reset();
      test_host();
      test_outputs();
      test_inputs();
      test_notify();
      finish_test();
   end
endmodule // dio_mode_control_bench
